// ==== hw/gcf_map.svh ====
`ifndef GCF_MAP_SVH
`define GCF_MAP_SVH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define GCF_ADDR_CTRL   8'h00
`define GCF_ADDR_TXDATA 8'h04
`define GCF_ADDR_RXDATA 8'h08
`define GCF_ADDR_STATUS 8'h0c

// ---------------------------------------------------------------
// control word fields
// ---------------------------------------------------------------
`define GCF_RATE_LO  4
`define GCF_RATE_HI  5
`define GCF_GC_BIT   6
`define GCF_FTX_BIT  7
`define GCF_FRX_BIT  8
`define GCF_DTX_BIT  9
`define GCF_DRX_BIT  10
`define GCF_RATE_STD  2'h0
`define GCF_RATE_FAST 2'h1

// ---------------------------------------------------------------
// receive word tag and fifo sizing
// ---------------------------------------------------------------
`define GCF_GC_TAG     8
`define GCF_FIFO_DEPTH 8
`define GCF_RX_HIGH    4'h7

// ---------------------------------------------------------------
// bit timing: half scl period in ref_clk cycles, rounded up
// ---------------------------------------------------------------
`define GCF_CLK_KHZ   50000
`define GCF_STD_KBPS  100
`define GCF_FAST_KBPS 400
`define GCF_HALF_STD  ((`GCF_CLK_KHZ + 2*`GCF_STD_KBPS - 1) / (2*`GCF_STD_KBPS))
`define GCF_HALF_FAST ((`GCF_CLK_KHZ + 2*`GCF_FAST_KBPS - 1) / (2*`GCF_FAST_KBPS))

`endif

// ==== hw/gcf_pkg.sv ====
package gcf_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } gcf_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } gcf_apb_rsp_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } gcf_tx_t;

    typedef struct packed {
        logic       valid;
        logic       gc;
        logic       gc_hw;
        logic [7:0] data;
    } gcf_rx_t;

    typedef struct packed {
        logic       fast;
        logic       gc_direct;
        logic [8:0] half;
    } gcf_cfg_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] code;
    } gcf_gc_act_t;

    typedef struct packed {
        logic tx;
        logic rx;
    } gcf_pair_t;

    typedef enum logic {
        GCF_FL_IDLE = 1'b0,
        GCF_FL_BUSY = 1'b1
    } gcf_flush_t;

endpackage

// ==== hw/gcf_sync.sv ====
`timescale 1ns/10ps
module gcf_sync #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } gcf_sync_st_t;

    gcf_sync_st_t s_r;
    gcf_sync_st_t s_nxt;

    // first stage feeds only the second
    always_comb begin
        s_nxt    = s_r;
        s_nxt.s1 = d;
        s_nxt.s2 = s_r.s1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.s2;
endmodule

// ==== hw/gcf_fifo.sv ====
`timescale 1ns/10ps
module gcf_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    input  wire logic                 clr,
    input  wire logic                 in_valid,
    input  wire logic [W-1:0]         in_data,
    output logic                      in_ready,
    output logic                      out_valid,
    output logic      [W-1:0]         out_data,
    input  wire logic                 out_ready,
    output logic      [$clog2(D):0]   level
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } gcf_fifo_st_t;

    gcf_fifo_st_t s_r;
    gcf_fifo_st_t s_nxt;
    logic         push;
    logic         pop;

    assign in_ready  = (s_r.cnt != (AW+1)'(D));
    assign out_valid = (s_r.cnt != '0);
    assign out_data  = s_r.mem[s_r.rp];
    assign level     = s_r.cnt;

    always_comb begin
        s_nxt = s_r;
        push  = in_valid & in_ready;
        pop   = out_valid & out_ready;
        if (push) begin
            s_nxt.mem[s_r.wp] = in_data;
            s_nxt.wp          = s_r.wp + 1'b1;
        end
        if (pop) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
        s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        // a clear drops pointers and count only; stale words are unreachable
        if (clr) begin
            s_nxt.wp  = '0;
            s_nxt.rp  = '0;
            s_nxt.cnt = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end
endmodule

// ==== hw/gcf_ctrl.sv ====
// Summary of operation
// - bit-rate select value 1 runs the bus in fast mode, up to 400 kbit/s.
// - bit-rate select is bits 5:4, resets 0; value 0 is standard, 100 kbit/s.
// - general-call handling 0: general call acted on after its fifo word is decoded.
// - general-call handling 1: act directly, store only the status code word.
// - hardware general call always handled transparently.
// - writing 1 to bit 7 flushes transmit fifo and fsm; cleared on completion.
// - flushes leave all configuration settings unchanged.
// - flush handshake passes through two ref_clk synchronizers and takes several cycles before clearing.
// - writing 1 to bit 8 flushes receive fifo and fsm; cleared on completion.
// - transmit dma enable bit 9 clears on end of transfer; never both dma enables.
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/10ps
`include "gcf_map.svh"
module gcf_ctrl (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    input  wire gcf_pkg::gcf_apb_req_t apb_req,
    output gcf_pkg::gcf_apb_rsp_t     apb_rsp,
    output gcf_pkg::gcf_tx_t          tx_out,
    input  wire logic                 tx_ready,
    input  wire gcf_pkg::gcf_rx_t     rx_in,
    output logic                      rx_ready,
    output gcf_pkg::gcf_cfg_t         cfg,
    output gcf_pkg::gcf_gc_act_t      gc_act,
    output gcf_pkg::gcf_pair_t        engine_flush,
    output gcf_pkg::gcf_pair_t        dma_req,
    input  wire gcf_pkg::gcf_pair_t   dma_eot
);
    import gcf_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  rate;
        gcf_cfg_t    cfg;
        gcf_flush_t  transmit_flush;
        gcf_flush_t  receive_flush;
        logic        dtx;
        logic        drx;
        logic [1:0]  treq;
        logic [1:0]  seen;
        logic [1:0]  eflush;
        logic [7:0]  stat;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        gcf_tx_t     txo;
        gcf_gc_act_t gca;
        logic        rx_rdy;
        logic        dreq_tx;
        logic        dreq_rx;
    } gcf_ctrl_st_t;

    gcf_ctrl_st_t s_r;
    gcf_ctrl_st_t s_nxt;

    logic [31:0] ctrl_word;
    logic [1:0]  req_s;
    logic [1:0]  ack_s;
    logic        setup;
    logic        access;
    logic [31:0] w;
    logic        tx_push;
    logic        tx_pop;
    logic        rx_push;
    logic        rx_pop;
    logic        tx_in_rdy;
    logic        tx_fv;
    logic [7:0]  tx_fd;
    logic [3:0]  tx_lvl;
    logic        rx_fv;
    logic [8:0]  rx_fd;
    logic [3:0]  rx_lvl;

    assign setup  = apb_req.psel & ~apb_req.penable & ~s_r.pready;
    assign access = apb_req.psel & apb_req.penable & s_r.pready;
    assign w      = apb_req.pwdata;

    // ---------------------------------------------------------------
    // data buffers
    // ---------------------------------------------------------------
    gcf_fifo #(
        .W (8),
        .D (`GCF_FIFO_DEPTH)
    ) u_txf (
        .clk       (ref_clk),
        .rst       (rst),
        .ce        (ce),
        .clr       (s_r.eflush[1]),
        .in_valid  (tx_push),
        .in_data   (w[7:0]),
        .in_ready  (tx_in_rdy),
        .out_valid (tx_fv),
        .out_data  (tx_fd),
        .out_ready (tx_pop),
        .level     (tx_lvl)
    );

    gcf_fifo #(
        .W (9),
        .D (`GCF_FIFO_DEPTH)
    ) u_rxf (
        .clk       (ref_clk),
        .rst       (rst),
        .ce        (ce),
        .clr       (s_r.eflush[0]),
        .in_valid  (rx_push),
        .in_data   ({rx_in.gc, rx_in.data}),
        .in_ready  (),
        .out_valid (rx_fv),
        .out_data  (rx_fd),
        .out_ready (rx_pop),
        .level     (rx_lvl)
    );

    // ---------------------------------------------------------------
    // flush handshake: request toggles out, seen level comes back
    // ---------------------------------------------------------------
    gcf_sync #(
        .W (2)
    ) u_req (
        .clk (ref_clk),
        .rst (rst),
        .ce  (ce),
        .d   (s_r.treq),
        .q   (req_s)
    );

    gcf_sync #(
        .W (2)
    ) u_ack (
        .clk (ref_clk),
        .rst (rst),
        .ce  (ce),
        .d   (s_r.seen),
        .q   (ack_s)
    );

    // ---------------------------------------------------------------
    // control word view
    // ---------------------------------------------------------------
    always_comb begin
        ctrl_word                           = '0;
        ctrl_word[`GCF_RATE_HI:`GCF_RATE_LO] = s_r.rate;
        ctrl_word[`GCF_GC_BIT]              = s_r.cfg.gc_direct;
        ctrl_word[`GCF_FTX_BIT]             = s_r.transmit_flush;
        ctrl_word[`GCF_FRX_BIT]             = s_r.receive_flush;
        ctrl_word[`GCF_DTX_BIT]             = s_r.dtx;
        ctrl_word[`GCF_DRX_BIT]             = s_r.drx;
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        s_nxt           = s_r;
        s_nxt.pready    = 1'b0;
        s_nxt.eflush    = '0;
        s_nxt.gca.valid = 1'b0;
        tx_push         = 1'b0;
        tx_pop          = 1'b0;
        rx_push         = 1'b0;
        rx_pop          = 1'b0;

        // completion: seen level has come back equal to the request
        if (s_r.transmit_flush == GCF_FL_BUSY && ack_s[1] == s_r.treq[1]) begin
            s_nxt.transmit_flush = GCF_FL_IDLE;
        end
        if (s_r.receive_flush == GCF_FL_BUSY && ack_s[0] == s_r.treq[0]) begin
            s_nxt.receive_flush = GCF_FL_IDLE;
        end

        // end of transfer drops the enable; a write below still wins
        if (dma_eot.tx) begin
            s_nxt.dtx = 1'b0;
        end
        if (dma_eot.rx) begin
            s_nxt.drx = 1'b0;
        end

        // apb setup: decode and prepare the answer
        if (setup) begin
            s_nxt.pready  = 1'b1;
            s_nxt.pslverr = 1'b0;
            s_nxt.prdata  = '0;
            case (apb_req.paddr)
                `GCF_ADDR_CTRL: begin
                    s_nxt.prdata = ctrl_word;
                end
                `GCF_ADDR_TXDATA: begin
                    // refused while flushing or full
                    s_nxt.pslverr = apb_req.pwrite &
                                    ((s_r.transmit_flush == GCF_FL_BUSY) | ~tx_in_rdy);
                end
                `GCF_ADDR_RXDATA: begin
                    s_nxt.pslverr = ~apb_req.pwrite &
                                    ((s_r.receive_flush == GCF_FL_BUSY) | ~rx_fv);
                    s_nxt.prdata  = 32'(rx_fd);
                end
                `GCF_ADDR_STATUS: begin
                    s_nxt.prdata = 32'({rx_lvl, tx_lvl, s_r.stat});
                end
                default: begin
                    s_nxt.pslverr = 1'b1;
                end
            endcase
        end

        // apb access: the write or pop takes effect at this edge
        if (access) begin
            if (apb_req.pwrite && apb_req.paddr == `GCF_ADDR_CTRL) begin
                s_nxt.rate          = w[`GCF_RATE_HI:`GCF_RATE_LO];
                s_nxt.cfg.fast      = (w[`GCF_RATE_HI:`GCF_RATE_LO] == `GCF_RATE_FAST);
                s_nxt.cfg.half      = s_nxt.cfg.fast ? 9'(`GCF_HALF_FAST)
                                                     : 9'(`GCF_HALF_STD);
                s_nxt.cfg.gc_direct = w[`GCF_GC_BIT];
                s_nxt.dtx           = w[`GCF_DTX_BIT];
                // both enables at once is illegal; transmit keeps priority
                s_nxt.drx           = w[`GCF_DRX_BIT] & ~w[`GCF_DTX_BIT];
                // zero is ignored, a one while busy starts nothing new
                if (w[`GCF_FTX_BIT] && s_nxt.transmit_flush == GCF_FL_IDLE) begin
                    s_nxt.transmit_flush     = GCF_FL_BUSY;
                    s_nxt.treq[1] = ~s_r.treq[1];
                end
                if (w[`GCF_FRX_BIT] && s_nxt.receive_flush == GCF_FL_IDLE) begin
                    s_nxt.receive_flush     = GCF_FL_BUSY;
                    s_nxt.treq[0] = ~s_r.treq[0];
                end
            end
            tx_push = apb_req.pwrite & (apb_req.paddr == `GCF_ADDR_TXDATA) & ~s_r.pslverr;
            rx_pop  = ~apb_req.pwrite & (apb_req.paddr == `GCF_ADDR_RXDATA) & ~s_r.pslverr;
        end

        // serial side: a new request resets its fifo and engine fsm, and on transmit also the output stage
        for (int i = 0; i < 2; i++) begin
            if (req_s[i] != s_r.seen[i]) begin
                s_nxt.seen[i]   = req_s[i];
                s_nxt.eflush[i] = 1'b1;
            end
        end

        // transmit output stage
        if (s_r.eflush[1]) begin
            s_nxt.txo.valid = 1'b0;
        end else if (!s_r.txo.valid || tx_ready) begin
            s_nxt.txo.valid = tx_fv;
            s_nxt.txo.data  = tx_fd;
            tx_pop          = tx_fv;
        end

        // transparent general call acts once its word is read back
        if (rx_pop && rx_fd[`GCF_GC_TAG]) begin
            s_nxt.gca.valid = 1'b1;
            s_nxt.gca.code  = rx_fd[7:0];
        end

        // receive input: direct general call bypasses the fifo
        if (rx_in.valid && s_r.rx_rdy) begin
            if (rx_in.gc && s_r.cfg.gc_direct && !rx_in.gc_hw) begin
                s_nxt.gca.valid = 1'b1;
                s_nxt.gca.code  = rx_in.data;
                s_nxt.stat      = rx_in.data;
            end else begin
                rx_push = 1'b1;
            end
        end

        // ready is one slot early so the registered lag never overflows
        s_nxt.rx_rdy  = (s_nxt.receive_flush == GCF_FL_IDLE) & ~s_r.eflush[0] &
                        (rx_lvl < `GCF_RX_HIGH);
        s_nxt.dreq_tx = s_nxt.dtx & tx_in_rdy & (s_nxt.transmit_flush == GCF_FL_IDLE);
        s_nxt.dreq_rx = s_nxt.drx & rx_fv & (s_nxt.receive_flush == GCF_FL_IDLE);
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_r          <= '0;
            s_r.cfg.half <= 9'(`GCF_HALF_STD);
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign apb_rsp.prdata   = s_r.prdata;
    assign apb_rsp.pready   = s_r.pready;
    assign apb_rsp.pslverr  = s_r.pslverr;
    assign tx_out           = s_r.txo;
    assign rx_ready         = s_r.rx_rdy;
    assign cfg              = s_r.cfg;
    assign gc_act           = s_r.gca;
    assign engine_flush.tx  = s_r.eflush[1];
    assign engine_flush.rx  = s_r.eflush[0];
    assign dma_req.tx       = s_r.dreq_tx;
    assign dma_req.rx       = s_r.dreq_rx;
endmodule

// ==== test/gcf_ctrl_props.sv ====
`timescale 1ns/10ps
`include "gcf_map.svh"
module gcf_ctrl_props (
    input wire logic                  ref_clk,
    input wire logic                  rst,
    input wire logic                  ce,
    input wire gcf_pkg::gcf_apb_req_t apb_req,
    input wire gcf_pkg::gcf_apb_rsp_t apb_rsp,
    input wire gcf_pkg::gcf_tx_t      tx_out,
    input wire logic                  tx_ready,
    input wire gcf_pkg::gcf_rx_t      rx_in,
    input wire logic                  rx_ready,
    input wire gcf_pkg::gcf_cfg_t     cfg,
    input wire gcf_pkg::gcf_gc_act_t  gc_act,
    input wire gcf_pkg::gcf_pair_t    engine_flush,
    input wire gcf_pkg::gcf_pair_t    dma_req,
    input wire gcf_pkg::gcf_pair_t    dma_eot
);
    import gcf_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    // a low clock enable freezes the design, so nothing can advance then
    default disable iff (rst || !ce);
    // ----------------------------------------
    // steps of a control write and a take
    // ----------------------------------------
    sequence ctrl_wr_s;
        apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == 8'h00;
    endsequence
    sequence gc_take_s;
        rx_in.valid && rx_ready && rx_in.gc;
    endsequence
    setup_ready_a: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
        else $error("no pready after setup");
    ready_once_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready longer than one cycle");
    bad_addr_a: assert property (apb_req.psel && apb_req.penable && apb_req.paddr > 8'h0c
        |-> apb_rsp.pslverr) else $error("unmapped access not refused");
    fast_half_a: assert property (cfg.fast |-> cfg.half == 9'h03f)
        else $error("fast half period wrong");
    std_half_a: assert property (!cfg.fast |-> cfg.half == 9'h0fa)
        else $error("standard half period wrong");
    tx_hold_a: assert property (tx_out.valid && !tx_ready && !engine_flush.tx
        |=> engine_flush.tx || (tx_out.valid && $stable(tx_out.data)))
        else $error("transmit byte not held");
    // a one written while the flush bit reads idle raises the engine flush within five cycles
    tx_flush_a: assert property (ctrl_wr_s ##0 apb_req.pwdata[7]
        ##0 !apb_rsp.prdata[7]
        |=> !engine_flush.tx ##[0:4] engine_flush.tx) else $error("no transmit flush");
    rx_flush_a: assert property (ctrl_wr_s ##0 apb_req.pwdata[8]
        ##0 !apb_rsp.prdata[8]
        |=> !engine_flush.rx ##[0:4] engine_flush.rx) else $error("no receive flush");
    flush_drop_a: assert property (engine_flush.tx |=> !tx_out.valid)
        else $error("transmit byte kept over flush");
    rx_block_a: assert property (engine_flush.rx |-> !rx_ready)
        else $error("receive open during flush");
    gc_direct_a: assert property (gc_take_s ##0 (cfg.gc_direct && !rx_in.gc_hw)
        |=> gc_act.valid && gc_act.code == $past(rx_in.data)) else $error("no direct action");
    // a tagged word popped in the same cycle may act legally
    gc_defer_a: assert property (gc_take_s ##0 (rx_in.gc_hw || !cfg.gc_direct)
        ##0 !(apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_req.paddr == 8'h08)
        |=> !gc_act.valid) else $error("action before decode");
    dma_excl_a: assert property (!(dma_req.tx && dma_req.rx))
        else $error("both dma requests");
    eot_clear_a: assert property (dma_eot.tx && !(apb_req.psel && apb_req.penable
        && apb_req.pwrite && apb_req.paddr == 8'h00) |=> !dma_req.tx)
        else $error("dma enable kept after end");
endmodule

// ==== test/gcf_eng_model.sv ====
`timescale 1ns/10ps
module gcf_eng_model (
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire gcf_pkg::gcf_tx_t   tx_out,
    output logic                    tx_ready,
    output gcf_pkg::gcf_rx_t        rx_in,
    input  wire logic               rx_ready,
    input  wire gcf_pkg::gcf_pair_t engine_flush
);
    import gcf_pkg::*;
    logic       stall = 1'b0;
    logic [7:0] txq[$];
    int         ftx_n = 0;
    int         frx_n = 0;
    initial begin
        tx_ready = 1'b0;
        rx_in = '0;
    end
    always @(posedge ref_clk) begin
        if (tx_out.valid === 1'b1 && tx_ready === 1'b1) begin
            txq.push_back(tx_out.data);
        end
        if (engine_flush.tx === 1'b1) begin
            ftx_n++;
        end
        if (engine_flush.rx === 1'b1) begin
            frx_n++;
        end
        tx_ready <= !stall && !rst;
    end
    // released lines show the inverse so a stale byte cannot pass
    task automatic send(input logic [7:0] d, input logic g, input logic h);
        rx_in <= '{1'b1, g, h, d};
        do begin
            @(posedge ref_clk);
        end while (rx_ready !== 1'b1);
        rx_in <= '{1'b0, ~g, ~h, ~d};
        @(posedge ref_clk);
    endtask
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/10ps
`include "gcf_map.svh"
module testbench;
    import gcf_pkg::*;
    logic         ref_clk;
    logic         rst;
    logic         ce;
    gcf_apb_req_t apb_req;
    gcf_apb_rsp_t apb_rsp;
    gcf_tx_t      tx_out;
    logic         tx_ready;
    gcf_rx_t      rx_in;
    logic         rx_ready;
    gcf_cfg_t     cfg;
    gcf_gc_act_t  gc_act;
    gcf_pair_t    engine_flush;
    gcf_pair_t    dma_req;
    gcf_pair_t    dma_eot;
    logic [31:0]  rd;
    logic         err;
    logic [7:0]   gc_code;
    int           failures = 0;
    int           check_count = 0;
    int           cyc = 0;
    int           gc_n = 0;
    int           n;
    int           k;
    logic [7:0]   row_w [6] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50};
    logic         row_f [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    logic [8:0]   row_h [6] = '{9'h0fa, 9'h03f, 9'h0fa, 9'h0fa, 9'h0fa, 9'h03f};
    gcf_ctrl dut_u (.ref_clk(ref_clk), .rst(rst), .ce(ce), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .tx_out(tx_out), .tx_ready(tx_ready), .rx_in(rx_in),
        .rx_ready(rx_ready), .cfg(cfg), .gc_act(gc_act), .engine_flush(engine_flush),
        .dma_req(dma_req), .dma_eot(dma_eot));
    gcf_eng_model eng_u (.ref_clk(ref_clk), .rst(rst), .tx_out(tx_out),
        .tx_ready(tx_ready), .rx_in(rx_in), .rx_ready(rx_ready),
        .engine_flush(engine_flush));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic conclude();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("ERROR %0t saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk);
    endtask
    // holds the request until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
        @(posedge ref_clk);
    endtask
    task automatic poll(input int b);
        apb(1'b0, `GCF_ADDR_CTRL, '0);
        chk(rd[b], 1'b1);
        n = 0;
        while (rd[b] !== 1'b0 && n < 4) begin
            apb(1'b0, `GCF_ADDR_CTRL, '0);
            n++;
        end
        chk(rd[b], 1'b0);
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (gc_act.valid === 1'b1) begin
            gc_n++;
            gc_code = gc_act.code;
        end
        if (cyc == 4000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        ce = 1'b1;
        rst = 1'b1;
        apb_req = '0;
        dma_eot = '0;
        tick(12);
        chk(cfg.half, 9'h0fa);
        rst <= 1'b0;
        tick(1);
        apb(1'b0, `GCF_ADDR_CTRL, '0);
        chk(rd, '0);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, `GCF_ADDR_CTRL, row_w[i]);
            apb(1'b0, `GCF_ADDR_CTRL, '0);
            chk(rd, row_w[i]);
            chk(cfg.fast, row_f[i]);
            chk(cfg.half, row_h[i]);
            chk(cfg.gc_direct, row_w[i][6]);
        end
        apb(1'b0, 8'h10, '0);
        chk(err, 1'b1);
        // fill the transmit fifo with the engine stalled
        eng_u.stall <= 1'b1;
        k = 0;
        do begin
            apb(1'b1, `GCF_ADDR_TXDATA, 32'h30 + k);
            k++;
        end while (err === 1'b0 && k < 12);
        k--;
        apb(1'b0, `GCF_ADDR_STATUS, '0);
        chk(rd[11:8], 4'h8);
        apb(1'b1, `GCF_ADDR_CTRL, 32'h250);
        chk(dma_req.tx, 1'b0);
        eng_u.stall <= 1'b0;
        tick(30);
        chk(eng_u.txq.size(), k);
        for (int i = 0; i < k; i++) chk(eng_u.txq[i], 32'h30 + i);
        chk(dma_req.tx, 1'b1);
        dma_eot <= '{1'b1, 1'b0};
        tick(1);
        dma_eot <= '0;
        tick(1);
        chk(dma_req.tx, 1'b0);
        apb(1'b0, `GCF_ADDR_CTRL, '0);
        chk(rd, 32'h50);
        apb(1'b1, `GCF_ADDR_CTRL, 32'h650);
        apb(1'b0, `GCF_ADDR_CTRL, '0);
        chk(rd, 32'h250);
        // flush with bytes waiting; other fields must survive
        eng_u.stall <= 1'b1;
        eng_u.txq.delete();
        for (int i = 0; i < 3; i++) apb(1'b1, `GCF_ADDR_TXDATA, i);
        apb(1'b1, `GCF_ADDR_CTRL, 32'h0d0);
        poll(7);
        chk(rd, 32'h50);
        chk(cfg.fast, 1'b1);
        apb(1'b0, `GCF_ADDR_STATUS, '0);
        chk(rd[11:8], 4'h0);
        chk(eng_u.ftx_n, 1);
        eng_u.stall <= 1'b0;
        tick(10);
        chk(eng_u.txq.size(), 0);
        apb(1'b1, `GCF_ADDR_CTRL, 32'h10);
        eng_u.send(8'h5a, 1'b0, 1'b0);
        eng_u.send(8'h77, 1'b1, 1'b0);
        chk(gc_n, 0);
        apb(1'b0, `GCF_ADDR_RXDATA, '0);
        chk(rd, 32'h5a);
        apb(1'b0, `GCF_ADDR_RXDATA, '0);
        chk(rd, 32'h177);
        tick(2);
        chk(gc_n, 1);
        chk(gc_code, 8'h77);
        apb(1'b0, `GCF_ADDR_RXDATA, '0);
        chk(err, 1'b1);
        apb(1'b1, `GCF_ADDR_CTRL, 32'h50);
        eng_u.send(8'ha5, 1'b1, 1'b0);
        tick(2);
        chk(gc_n, 2);
        chk(gc_code, 8'ha5);
        apb(1'b0, `GCF_ADDR_STATUS, '0);
        chk(rd, 32'ha5);
        eng_u.send(8'h3c, 1'b1, 1'b1);
        tick(2);
        chk(gc_n, 2);
        apb(1'b0, `GCF_ADDR_RXDATA, '0);
        chk(rd, 32'h13c);
        eng_u.send(8'h11, 1'b0, 1'b0);
        apb(1'b1, `GCF_ADDR_CTRL, 32'h450);
        chk(dma_req.rx, 1'b1);
        apb(1'b1, `GCF_ADDR_CTRL, 32'h150);
        poll(8);
        chk(rd, 32'h50);
        chk(eng_u.frx_n, 1);
        apb(1'b0, `GCF_ADDR_RXDATA, '0);
        chk(err, 1'b1);
        // a frozen clock enable loses the end-of-transfer pulse
        apb(1'b1, `GCF_ADDR_CTRL, 32'h250);
        ce <= 1'b0;
        dma_eot <= '{1'b1, 1'b0};
        tick(1);
        dma_eot <= '0;
        tick(2);
        chk(dma_req.tx, 1'b1);
        // mid-run reset returns every field to its reset value
        ce <= 1'b1;
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(1);
        chk(dma_req.tx, 1'b0);
        chk(cfg.half, 9'h0fa);
        apb(1'b0, `GCF_ADDR_CTRL, '0);
        chk(rd, '0);
        conclude();
    end
endmodule
bind gcf_ctrl gcf_ctrl_props chk_u (.ref_clk(ref_clk), .rst(rst), .ce(ce), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .tx_out(tx_out), .tx_ready(tx_ready), .rx_in(rx_in),
    .rx_ready(rx_ready), .cfg(cfg), .gc_act(gc_act), .engine_flush(engine_flush),
    .dma_req(dma_req), .dma_eot(dma_eot));
